// ### hw/ucf_defines.vh
// Register offsets, field positions, command codes and timing counts for the channel block.
`ifndef UCF_DEFINES_VH
`define UCF_DEFINES_VH
`define UCF_ADDR_W         4
`define UCF_OFF_MODE       4'h0
`define UCF_OFF_STATUS     4'h1
`define UCF_OFF_COMMAND    4'h2
`define UCF_OFF_DATA       4'h3
`define UCF_OFF_MODE_ZERO  4'h4
`define UCF_OFF_OUT_LATCH  4'h5
`define UCF_M1_FLOW        7
`define UCF_M1_LEVEL_LO    6
`define UCF_M1_ERRMODE     5
`define UCF_M1_PAR_HI      4
`define UCF_M1_PAR_LO      3
`define UCF_M1_PAR_SENSE   2
`define UCF_M1_LEN_HI      1
`define UCF_M1_LEN_LO      0
`define UCF_M0_LEVEL_HI    6
`define UCF_M0_DEPTH       3
`define UCF_PAR_NORMAL     2'h0
`define UCF_PAR_FORCE      2'h1
`define UCF_PAR_NONE       2'h2
`define UCF_PAR_MULTIDROP  2'h3
`define UCF_CMD_SET_PTR    8'h01
`define UCF_CMD_RESET_ERR  8'h04
`define UCF_MODE1_RESET    8'h00
`define UCF_MODE2_RESET    8'h00
`define UCF_MODE0_RESET    8'h00
`define UCF_LATCH_RESET    8'h00
`define UCF_LVL8_0         5'h01
`define UCF_LVL8_1         5'h03
`define UCF_LVL8_2         5'h06
`define UCF_LVL8_3         5'h08
`define UCF_LVL16_0        5'h01
`define UCF_LVL16_1        5'h08
`define UCF_LVL16_2        5'h0c
`define UCF_LVL16_3        5'h10
`define UCF_CLK_HZ         100000000
`define UCF_BAUD           115200
`define UCF_OVERSAMPLE     16
`define UCF_BAUD_DIV       ((`UCF_CLK_HZ) / ((`UCF_BAUD) * (`UCF_OVERSAMPLE)))
`endif

// ### hw/ucf_rx_fifo.v
// Receive FIFO with a selectable logical depth of 8 or 16 entries.
`timescale 1ns/10ps
module ucf_rx_fifo
#(
  parameter WIDTH = 11,
  parameter DEPTH = 16
)
(
  // Clock and reset
  input  wire             ref_clk,
  input  wire             rst,
  // Control
  input  wire             deep_sel,
  input  wire             push,
  input  wire [WIDTH-1:0] push_data,
  input  wire             pop,
  // State
  output wire [WIDTH-1:0] top,
  output wire [4:0]       count,
  output wire             full,
  output wire             empty
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [3:0]       wr_ptr_q;
  reg [3:0]       rd_ptr_q;
  reg [4:0]       count_q;
  wire            do_push;
  wire            do_pop;
  wire [4:0]      limit;

  // The shallow setting only lowers the fill limit, so storage stays one array.
  assign limit   = deep_sel ? 5'h10 : 5'h08;
  assign full    = (count_q >= limit);
  assign empty   = (count_q == 5'h00);
  assign count   = count_q;
  assign top     = mem[rd_ptr_q];
  assign do_push = push & ~full;
  assign do_pop  = pop & ~empty;

  always @(posedge ref_clk)
  begin
    if (do_push)
    begin
      mem[wr_ptr_q] <= push_data;
    end
  end

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
      count_q  <= 5'h00;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr_q <= wr_ptr_q + 4'h1;
      end
      if (do_pop)
      begin
        rd_ptr_q <= rd_ptr_q + 4'h1;
      end
      if (do_push & ~do_pop)
      begin
        count_q <= count_q + 5'h01;
      end
      else if (do_pop & ~do_push)
      begin
        count_q <= count_q - 5'h01;
      end
    end
  end
endmodule // ucf_rx_fifo

// ### hw/ucf_channel.v
// Channel A format and receiver flow-control logic with a small serial transmitter and receiver.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
`include "ucf_defines.vh"
module ucf_channel
#(
  parameter BAUD_DIV = `UCF_BAUD_DIV
)
(
  // Clock and reset
  input  wire                   ref_clk,
  input  wire                   rst,
  // Register port
  input  wire [`UCF_ADDR_W-1:0] reg_addr,
  input  wire [7:0]             reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [7:0]             reg_rdata,
  // Serial lines
  input  wire                   rx_line,
  output reg                    tx_line,
  // Output port pins, active low
  output reg                    chan_a_request_to_send_n,
  output reg  [7:1]             output_port_n,
  // Receive fill level reached
  output wire                   rx_fill_level_hit
);
  localparam S_IDLE  = 3'h0;
  localparam S_START = 3'h1;
  localparam S_DATA  = 3'h2;
  localparam S_PAR   = 3'h3;
  localparam S_STOP  = 3'h4;
  localparam S_MARK  = 3'h5;

  reg  [7:0]  mode_word_one_chan_a_q;
  reg  [7:0]  mode_word_two_chan_a_q;
  reg  [7:0]  mode_word_zero_q;
  reg  [7:0]  output_port_latch_q;
  reg         ptr_two_q;
  reg  [15:0] div_q;
  reg         tick_q;
  reg         rx_s1_q;
  reg         rx_s2_q;
  reg  [2:0]  rst_q;
  reg  [3:0]  rtick_q;
  reg  [2:0]  rbit_q;
  reg  [7:0]  rshift_q;
  reg         rpar_q;
  reg         rpar_bit_q;
  reg         drop_q;
  reg  [10:0] hold_q;
  reg         hold_valid_q;
  reg         rts_neg_q;
  reg         overrun_q;
  reg  [2:0]  accum_q;
  reg  [2:0]  tst_q;
  reg  [3:0]  ttick_q;
  reg  [2:0]  tbit_q;
  reg  [7:0]  tshift_q;
  reg         tpar_q;
  reg  [7:0]  tx_hold_q;
  reg         tx_hold_valid_q;
  reg  [4:0]  level;
  reg  [2:0]  rx_err;
  reg         exp_par;
  reg         char_done;
  reg  [10:0] char_word;

  wire [1:0]  par_mode;
  wire        par_sense;
  wire [2:0]  last_bit;
  wire        par_on;
  wire        start_seen;
  wire        push;
  wire [10:0] push_data;
  wire        pop;
  wire [10:0] top;
  wire [4:0]  count;
  wire        full;
  wire        empty;
  wire        deep_sel;
  wire [2:0]  err_view;
  wire        cmd_wr;
  wire [7:0]  status;

  assign par_mode  = mode_word_one_chan_a_q[`UCF_M1_PAR_HI:`UCF_M1_PAR_LO];
  assign par_sense = mode_word_one_chan_a_q[`UCF_M1_PAR_SENSE];
  assign last_bit  = 3'h4 + {1'b0, mode_word_one_chan_a_q[`UCF_M1_LEN_HI:`UCF_M1_LEN_LO]};
  assign par_on    = (par_mode != `UCF_PAR_NONE);
  assign deep_sel  = mode_word_zero_q[`UCF_M0_DEPTH];
  assign cmd_wr    = reg_wr & (reg_addr == `UCF_OFF_COMMAND);

  // Baud divider gives a one-cycle enable at sixteen times the bit rate.
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      div_q  <= 16'h0000;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (div_q == BAUD_DIV[15:0] - 16'h0001);
      div_q  <= (div_q == BAUD_DIV[15:0] - 16'h0001) ? 16'h0000 : div_q + 16'h0001;
    end
  end

  // Register port, mode pointer and output latch.
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      mode_word_one_chan_a_q <= `UCF_MODE1_RESET;
      mode_word_two_chan_a_q <= `UCF_MODE2_RESET;
      mode_word_zero_q       <= `UCF_MODE0_RESET;
      output_port_latch_q    <= `UCF_LATCH_RESET;
      ptr_two_q              <= 1'b0;
    end
    else
    begin
      if ((reg_wr | reg_rd) & (reg_addr == `UCF_OFF_MODE))
      begin
        ptr_two_q <= 1'b1;
      end
      if (cmd_wr & (reg_wdata == `UCF_CMD_SET_PTR))
      begin
        ptr_two_q <= 1'b0;
      end
      if (reg_wr & (reg_addr == `UCF_OFF_MODE) & ~ptr_two_q)
      begin
        mode_word_one_chan_a_q <= reg_wdata;
      end
      if (reg_wr & (reg_addr == `UCF_OFF_MODE) & ptr_two_q)
      begin
        mode_word_two_chan_a_q <= reg_wdata;
      end
      if (reg_wr & (reg_addr == `UCF_OFF_MODE_ZERO))
      begin
        mode_word_zero_q <= reg_wdata;
      end
      // Flow control never rewrites the latch; only software does.
      if (reg_wr & (reg_addr == `UCF_OFF_OUT_LATCH))
      begin
        output_port_latch_q <= reg_wdata;
      end
    end
  end

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        `UCF_OFF_MODE:      reg_rdata <= ptr_two_q ? mode_word_two_chan_a_q
                                                   : mode_word_one_chan_a_q;
        `UCF_OFF_STATUS:    reg_rdata <= status;
        `UCF_OFF_DATA:      reg_rdata <= top[7:0];
        `UCF_OFF_MODE_ZERO: reg_rdata <= mode_word_zero_q;
        `UCF_OFF_OUT_LATCH: reg_rdata <= output_port_latch_q;
        default:            reg_rdata <= 8'h00;
      endcase
    end
    else
    begin
      reg_rdata <= 8'h00;
    end
  end

  // The line is asynchronous; only the second stage is read.
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end
    else
    begin
      rx_s1_q <= rx_line;
      rx_s2_q <= rx_s1_q;
    end
  end

  // Receive checks evaluated at the stop-bit sample.
  always @*
  begin
    exp_par   = (par_mode == `UCF_PAR_NORMAL) ? (rpar_q ^ par_sense) : par_sense;
    rx_err    = 3'h0;
    rx_err[0] = ((par_mode == `UCF_PAR_NORMAL) | (par_mode == `UCF_PAR_FORCE))
                & (rpar_bit_q != exp_par);
    // Multi-drop keeps the received address flag in the parity slot.
    if (par_mode == `UCF_PAR_MULTIDROP)
    begin
      rx_err[0] = rpar_bit_q;
    end
    rx_err[1] = ~rx_s2_q;
    rx_err[2] = ~rx_s2_q & (rshift_q == 8'h00) & ~(par_on & rpar_bit_q);
    char_done = tick_q & (rst_q == S_STOP) & (rtick_q == 4'hf);
    char_word = {rx_err, rshift_q};
  end

  assign start_seen = tick_q & (rst_q == S_START) & (rtick_q == 4'h7) & ~rx_s2_q;

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      rst_q      <= S_IDLE;
      rtick_q    <= 4'h0;
      rbit_q     <= 3'h0;
      rshift_q   <= 8'h00;
      rpar_q     <= 1'b0;
      rpar_bit_q <= 1'b0;
    end
    else if (tick_q)
    begin
      rtick_q <= rtick_q + 4'h1;
      case (rst_q)
        S_IDLE:
        begin
          rtick_q <= 4'h0;
          if (~rx_s2_q)
          begin
            rst_q <= S_START;
          end
        end
        S_START:
        begin
          if (rtick_q == 4'h7)
          begin
            rtick_q  <= 4'h0;
            rbit_q   <= 3'h0;
            rshift_q <= 8'h00;
            rpar_q   <= 1'b0;
            rst_q    <= rx_s2_q ? S_IDLE : S_DATA;
          end
        end
        S_DATA:
        begin
          if (rtick_q == 4'hf)
          begin
            rshift_q[rbit_q] <= rx_s2_q;
            rpar_q           <= rpar_q ^ rx_s2_q;
            rbit_q           <= rbit_q + 3'h1;
            if (rbit_q == last_bit)
            begin
              rst_q <= par_on ? S_PAR : S_STOP;
            end
          end
        end
        S_PAR:
        begin
          if (rtick_q == 4'hf)
          begin
            rpar_bit_q <= rx_s2_q;
            rst_q      <= S_STOP;
          end
        end
        S_STOP:
        begin
          if (rtick_q == 4'hf)
          begin
            rpar_bit_q <= 1'b0;
            rst_q      <= rx_s2_q ? S_IDLE : S_MARK;
          end
        end
        S_MARK:
        begin
          if (rx_s2_q)
          begin
            rst_q <= S_IDLE;
          end
        end
        default: rst_q <= S_IDLE;
      endcase
    end
  end

  // One byte waits in a holding stage behind a full FIFO, as the shift register would.
  assign push      = ~full & (hold_valid_q | (char_done & ~drop_q));
  assign push_data = hold_valid_q ? hold_q : char_word;
  assign pop       = reg_rd & (reg_addr == `UCF_OFF_DATA);

  ucf_rx_fifo
  #(
    .WIDTH (11),
    .DEPTH (16)
  )
  u_rx_fifo
  (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .deep_sel  (deep_sel),
    .push      (push),
    .push_data (push_data),
    .pop       (pop),
    .top       (top),
    .count     (count),
    .full      (full),
    .empty     (empty)
  );

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      hold_q       <= 11'h000;
      hold_valid_q <= 1'b0;
      drop_q       <= 1'b0;
      rts_neg_q    <= 1'b0;
      overrun_q    <= 1'b0;
      accum_q      <= 3'h0;
    end
    else
    begin
      if (start_seen)
      begin
        drop_q <= full & hold_valid_q;
      end
      if (char_done & ~drop_q & (full | hold_valid_q))
      begin
        hold_q       <= char_word;
        hold_valid_q <= 1'b1;
      end
      else if (push & hold_valid_q)
      begin
        hold_valid_q <= 1'b0;
      end
      if (~full | ~mode_word_one_chan_a_q[`UCF_M1_FLOW])
      begin
        rts_neg_q <= 1'b0;
      end
      else if (start_seen)
      begin
        rts_neg_q <= 1'b1;
      end
      // A new error in the clearing cycle survives the reset-error command.
      if (cmd_wr & (reg_wdata == `UCF_CMD_RESET_ERR))
      begin
        overrun_q <= start_seen & full & hold_valid_q;
        accum_q   <= empty ? 3'h0 : top[10:8];
      end
      else
      begin
        overrun_q <= overrun_q | (start_seen & full & hold_valid_q);
        accum_q   <= accum_q | (empty ? 3'h0 : top[10:8]);
      end
    end
  end

  assign err_view = mode_word_one_chan_a_q[`UCF_M1_ERRMODE] ? accum_q
                                                          : (empty ? 3'h0 : top[10:8]);

  always @*
  begin
    case ({mode_word_zero_q[`UCF_M0_LEVEL_HI], mode_word_one_chan_a_q[`UCF_M1_LEVEL_LO]})
      2'h0:    level = deep_sel ? `UCF_LVL16_0 : `UCF_LVL8_0;
      2'h1:    level = deep_sel ? `UCF_LVL16_1 : `UCF_LVL8_1;
      2'h2:    level = deep_sel ? `UCF_LVL16_2 : `UCF_LVL8_2;
      default: level = deep_sel ? `UCF_LVL16_3 : `UCF_LVL8_3;
    endcase
  end

  assign rx_fill_level_hit = (count >= level);
  assign status = {err_view[2], err_view[1], err_view[0], overrun_q,
                   rx_fill_level_hit, ~tx_hold_valid_q, full, ~empty};

  // Flow control only works while software holds latch bit zero at one.
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      chan_a_request_to_send_n <= 1'b1;
      output_port_n            <= 7'h7f;
    end
    else
    begin
      chan_a_request_to_send_n <= ~output_port_latch_q[0] | rts_neg_q;
      output_port_n            <= ~output_port_latch_q[7:1];
    end
  end

  // Transmitter: start, data bits, optional parity, one stop bit.
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      tst_q           <= S_IDLE;
      ttick_q         <= 4'h0;
      tbit_q          <= 3'h0;
      tshift_q        <= 8'h00;
      tpar_q          <= 1'b0;
      tx_line         <= 1'b1;
      tx_hold_q       <= 8'h00;
      tx_hold_valid_q <= 1'b0;
    end
    else
    begin
      if (reg_wr & (reg_addr == `UCF_OFF_DATA) & ~tx_hold_valid_q)
      begin
        tx_hold_q       <= reg_wdata;
        tx_hold_valid_q <= 1'b1;
      end
      if (tick_q)
      begin
        ttick_q <= ttick_q + 4'h1;
        case (tst_q)
          S_IDLE:
          begin
            ttick_q <= 4'h0;
            if (tx_hold_valid_q)
            begin
              tshift_q        <= tx_hold_q;
              tx_hold_valid_q <= 1'b0;
              tbit_q          <= 3'h0;
              tpar_q          <= (par_mode == `UCF_PAR_NORMAL) ? par_sense : 1'b0;
              tx_line         <= 1'b0;
              tst_q           <= S_START;
            end
          end
          S_START:
          begin
            if (ttick_q == 4'hf)
            begin
              tx_line <= tshift_q[0];
              tpar_q  <= tpar_q ^ tshift_q[0];
              tst_q   <= S_DATA;
            end
          end
          S_DATA:
          begin
            if (ttick_q == 4'hf)
            begin
              tbit_q <= tbit_q + 3'h1;
              if (tbit_q == last_bit)
              begin
                // Forced and multi-drop modes send the sense bit itself.
                tx_line <= par_on ? ((par_mode == `UCF_PAR_NORMAL) ? tpar_q : par_sense)
                                  : 1'b1;
                tst_q   <= par_on ? S_PAR : S_STOP;
              end
              else
              begin
                tx_line <= tshift_q[tbit_q + 3'h1];
                tpar_q  <= tpar_q ^ tshift_q[tbit_q + 3'h1];
              end
            end
          end
          S_PAR:
          begin
            if (ttick_q == 4'hf)
            begin
              tx_line <= 1'b1;
              tst_q   <= S_STOP;
            end
          end
          S_STOP:
          begin
            if (ttick_q == 4'hf)
            begin
              tst_q <= S_IDLE;
            end
          end
          default: tst_q <= S_IDLE;
        endcase
      end
    end
  end
endmodule // ucf_channel

// ### bench/ucf_channel_sva.sv
// Checker for the register port, output port pins and request-to-send of the channel block.
`timescale 1ns/10ps
`include "ucf_defines.vh"
module ucf_channel_sva
(
  // Clock and reset
  input wire logic                   ref_clk,
  input wire logic                   rst,
  // Register port
  input wire logic [`UCF_ADDR_W-1:0] reg_addr,
  input wire logic [7:0]             reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [7:0]             reg_rdata,
  // Serial and pins
  input wire logic                   rx_line,
  input wire logic                   tx_line,
  input wire logic                   chan_a_request_to_send_n,
  input wire logic [7:1]             output_port_n,
  input wire logic                   rx_fill_level_hit
);
  logic       ptr_q;
  logic [7:0] m1_q;
  logic [7:0] lat_q;

  // Shadow copies of the pointer, mode one and the latch, tracked from bus traffic alone.
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      ptr_q <= 1'b0;
      m1_q  <= 8'h00;
      lat_q <= 8'h00;
    end
    else
    begin
      if ((reg_wr || reg_rd) && reg_addr == `UCF_OFF_MODE)
        ptr_q <= 1'b1;
      if (reg_wr && reg_addr == `UCF_OFF_MODE && !ptr_q)
        m1_q <= reg_wdata;
      if (reg_wr && reg_addr == `UCF_OFF_OUT_LATCH)
        lat_q <= reg_wdata;
      if (reg_wr && reg_addr == `UCF_OFF_COMMAND && reg_wdata == `UCF_CMD_SET_PTR)
        ptr_q <= 1'b0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  rst_pins_a: assert property ($fell(rst) |-> chan_a_request_to_send_n && tx_line
    && output_port_n == 7'h7f) else $error("pins not idle after reset");
  fill_reset_a: assert property ($fell(rst) |-> !rx_fill_level_hit)
    else $error("fill level hit after reset");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  unmapped_zero_a: assert property (reg_rd && reg_addr > 4'h5 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  mode_one_read_a: assert property (reg_rd && reg_addr == `UCF_OFF_MODE && !ptr_q
    |=> reg_rdata == m1_q) else $error("mode one read mismatch");
  port_follow_a: assert property (reg_wr && reg_addr == `UCF_OFF_OUT_LATCH
    |-> ##2 output_port_n == ~lat_q[7:1]) else $error("output pins do not follow latch");
  rts_no_flow_a: assert property ((!m1_q[7] && lat_q[0])[*4]
    |-> !chan_a_request_to_send_n) else $error("request-to-send negated without flow");
  rts_latch_off_a: assert property ((!lat_q[0])[*4] |-> chan_a_request_to_send_n)
    else $error("request-to-send asserted with latch bit clear");

  latch_set_c: cover property (reg_wr && reg_addr == `UCF_OFF_OUT_LATCH && reg_wdata[0]);
  rts_negate_c: cover property (m1_q[7] && $rose(chan_a_request_to_send_n));
  fill_hit_c: cover property ($rose(rx_fill_level_hit));
endmodule // ucf_channel_sva

bind ucf_channel ucf_channel_sva u_sva
(
  .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_line(rx_line),
  .tx_line(tx_line), .chan_a_request_to_send_n(chan_a_request_to_send_n),
  .output_port_n(output_port_n), .rx_fill_level_hit(rx_fill_level_hit)
);

// ### bench/ucf_remote_tx.sv
// Remote serial transmitter that shifts out a prepared frame, optionally paced by request-to-send.
`timescale 1ns/10ps
module ucf_remote_tx
#(
  parameter int BIT_CLKS = 32
)
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Control from the bench
  input  wire logic        chan_a_request_to_send_n,
  input  wire logic        honor_rts,
  input  wire logic        go,
  input  wire logic [11:0] frame,
  input  wire logic [3:0]  nbits,
  // Line
  output logic             rx_line,
  output logic             busy
);
  logic [11:0] sh;
  logic [3:0]  n;
  logic [7:0]  cnt;
  logic        started;

  // The request line is only looked at before a frame, so a negation mid-frame lets it finish.
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      rx_line <= 1'b1;
      busy    <= 1'b0;
      started <= 1'b0;
    end
    else if (!busy)
    begin
      if (go)
      begin
        sh      <= frame;
        n       <= nbits;
        cnt     <= 8'h00;
        busy    <= 1'b1;
        started <= 1'b0;
      end
    end
    else if (!started)
      started <= !honor_rts || !chan_a_request_to_send_n;
    else
    begin
      if (cnt == 8'h00 && n == 4'h0)
        busy <= 1'b0;
      else if (cnt == 8'h00)
      begin
        rx_line <= sh[0];
        sh      <= sh >> 1;
        n       <= n - 4'h1;
      end
      cnt <= (cnt == BIT_CLKS - 1) ? 8'h00 : cnt + 8'h01;
    end
  end
endmodule // ucf_remote_tx

// ### bench/ucf_channel_tb_top.sv
// Self-checking testbench for the channel format and receiver flow-control block.
`timescale 1ns/10ps
`include "ucf_defines.vh"
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module ucf_channel_tb_top;
  typedef struct {logic [7:0] mode; logic [7:0] data; int len; logic hp; logic pb;
    logic [7:0] exp_d; logic exp_par_err;} ucf_row_t;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        rx_line, tx_line, rts_n, hit, go = 1'b0, busy;
  logic [7:1]  port_n;
  logic [11:0] frame = 12'h000;
  logic [3:0]  nbits = 4'h0;
  logic [7:0]  d;
  logic [9:0]  f10;
  int          n_mismatch = 0;
  int          check_count = 0;
  ucf_row_t    rows [8] = '{'{8'h03, 8'ha5, 8, 1, 0, 8'ha5, 0}, '{8'h03, 8'ha5, 8, 1, 1, 8'ha5, 1},
    '{8'h07, 8'ha5, 8, 1, 1, 8'ha5, 0}, '{8'h00, 8'hf3, 5, 1, 1, 8'h13, 0},
    '{8'h11, 8'hea, 6, 0, 0, 8'h2a, 0}, '{8'h0e, 8'hd5, 7, 1, 1, 8'h55, 0},
    '{8'h0e, 8'hd5, 7, 1, 0, 8'h55, 1}, '{8'h1b, 8'h42, 8, 1, 1, 8'h42, 1}};

  always #5 ref_clk = ~ref_clk;

  ucf_channel #(.BAUD_DIV(2)) u_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_line(rx_line), .tx_line(tx_line), .chan_a_request_to_send_n(rts_n),
    .output_port_n(port_n), .rx_fill_level_hit(hit));
  ucf_remote_tx #(.BIT_CLKS(32)) u_far (.ref_clk(ref_clk), .rst(rst),
    .chan_a_request_to_send_n(rts_n), .honor_rts(1'b0), .go(go), .frame(frame),
    .nbits(nbits), .rx_line(rx_line), .busy(busy));

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Frame is start, data LSB first, optional parity, one stop bit.
  task automatic send(input logic [7:0] v, input int len, input logic hp, input logic pb);
    logic [11:0] f;
    int          n;
    f = 12'h000;
    for (n = 0; n < len; n++)
      f[n+1] = v[n];
    n = len + 1;
    f[n] = pb;
    n = n + hp;
    f[n] = 1'b1;
    @(posedge ref_clk);
    frame <= f;
    nbits <= 4'(n + 1);
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    @(posedge ref_clk);
    for (n = 0; n < 1000 && busy; n++)
      @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
  endtask

  task give_verdict;
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge ref_clk);
    n_mismatch++;
    give_verdict();
  end

  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    #1 `CHK("port pins", 7'h7f, port_n)
    rd(`UCF_OFF_STATUS);
    `CHK("status reset", 8'h04, d)
    rd(`UCF_OFF_MODE);
    `CHK("mode one reset", 8'h00, d)
    wr(`UCF_OFF_MODE, 8'h5a);
    rd(`UCF_OFF_MODE);
    `CHK("mode two", 8'h5a, d)
    wr(`UCF_OFF_COMMAND, `UCF_CMD_SET_PTR);
    rd(`UCF_OFF_MODE);
    `CHK("mode one again", 8'h00, d)
    rd(4'hf);
    `CHK("unmapped", 8'h00, d)
    foreach (rows[i])
    begin
      wr(`UCF_OFF_COMMAND, `UCF_CMD_SET_PTR);
      wr(`UCF_OFF_MODE, rows[i].mode);
      send(rows[i].data, rows[i].len, rows[i].hp, rows[i].pb);
      rd(`UCF_OFF_STATUS);
      `CHK("row status", {2'b00, rows[i].exp_par_err, 5'h01}, d & 8'he1)
      rd(`UCF_OFF_DATA);
      `CHK("row data", rows[i].exp_d, d)
    end
    // Software enables the latch bit before flow control can act.
    wr(`UCF_OFF_OUT_LATCH, 8'h81);
    repeat (3) @(posedge ref_clk);
    `CHK("latch pins", 7'h3f, port_n)
    `CHK("rts asserted", 1'b0, rts_n)
    wr(`UCF_OFF_MODE_ZERO, 8'h00);
    wr(`UCF_OFF_COMMAND, `UCF_CMD_SET_PTR);
    wr(`UCF_OFF_MODE, 8'hd3);
    for (int k = 1; k <= 10; k++)
    begin
      send(8'(k), 8, 1'b0, 1'b0);
      if (k <= 8)
        `CHK("fill level", k >= 3, hit)
      `CHK("rts_n", k >= 9, rts_n)
    end
    rd(`UCF_OFF_STATUS);
    `CHK("full overrun", 8'h12, d & 8'h12)
    rd(`UCF_OFF_OUT_LATCH);
    `CHK("latch kept", 8'h81, d)
    wr(`UCF_OFF_MODE_ZERO, 8'h40);
    repeat (2) @(posedge ref_clk);
    `CHK("fill eight", 1'b1, hit)
    rd(`UCF_OFF_DATA);
    `CHK("oldest byte", 8'h01, d)
    repeat (4) @(posedge ref_clk);
    `CHK("rts back", 1'b0, rts_n)
    rd(`UCF_OFF_DATA);
    repeat (2) @(posedge ref_clk);
    `CHK("fill seven", 1'b0, hit)
    wr(`UCF_OFF_MODE_ZERO, 8'h08);
    repeat (2) @(posedge ref_clk);
    `CHK("deep level", 1'b0, hit)
    for (int k = 3; k <= 9; k++)
    begin
      rd(`UCF_OFF_DATA);
      `CHK("drain", 8'(k), d)
    end
    wr(`UCF_OFF_COMMAND, `UCF_CMD_RESET_ERR);
    wr(`UCF_OFF_COMMAND, `UCF_CMD_SET_PTR);
    wr(`UCF_OFF_MODE, 8'h23);
    send(8'ha5, 8, 1'b1, 1'b1);
    send(8'ha5, 8, 1'b1, 1'b0);
    rd(`UCF_OFF_DATA);
    rd(`UCF_OFF_STATUS);
    `CHK("block error", 8'h21, d & 8'h31)
    wr(`UCF_OFF_COMMAND, `UCF_CMD_RESET_ERR);
    rd(`UCF_OFF_DATA);
    rd(`UCF_OFF_STATUS);
    `CHK("block cleared", 8'h00, d & 8'h21)
    // Transmit side: forced odd-sense parity, seven data bits, sampled at bit centres.
    wr(`UCF_OFF_COMMAND, `UCF_CMD_SET_PTR);
    wr(`UCF_OFF_MODE, 8'h0e);
    wr(`UCF_OFF_DATA, 8'hd5);
    for (int k = 0; k < 100 && tx_line; k++)
      @(posedge ref_clk);
    repeat (16) @(posedge ref_clk);
    for (int k = 0; k < 10; k++)
    begin
      f10[k] = tx_line;
      repeat (32) @(posedge ref_clk);
    end
    `CHK("tx frame", 10'h3aa, f10)
    wr(`UCF_OFF_COMMAND, `UCF_CMD_SET_PTR);
    wr(`UCF_OFF_MODE, 8'h23);
    send(8'ha5, 8, 1'b1, 1'b1);
    rd(`UCF_OFF_DATA);
    rd(`UCF_OFF_STATUS);
    `CHK("block kept", 8'h20, d & 8'h21)
    // A mid-run reset must also empty the accumulated error status.
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    wr(`UCF_OFF_COMMAND, `UCF_CMD_SET_PTR);
    wr(`UCF_OFF_MODE, 8'h23);
    rd(`UCF_OFF_STATUS);
    `CHK("reset clears block", 8'h04, d)
    give_verdict();
  end
endmodule // ucf_channel_tb_top
